// File: rtl/clr_responder.sv
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "clr_map.svh"
// Behaviour
// - Execution runs only when the opcode register holds 0fa2.
// - Bit 21 of the control word is freely writable and reads back.
// - The leaf comes from EAX as it stands; results land in EAX to EDX.
// - Standard leaves 0 to 2 and extended leaves 80000000h to 5h answer.
// - Leaf 1 and leaf 80000001h return the version and feature words.
// - Leaf 2 returns the TLB and cache descriptors.
// - Extended leaves 2h to 4h together return the product name.
// - Extended leaf 5h returns the TLB and first-level cache words.
// - Leaf 0 returns the highest standard leaf, 2, in EAX.
// - Leaf 0 returns the vendor string in EBX, then EDX, then ECX.
// - Leaf 1 EAX holds stepping, model, family and type, upper half zero.
// - Leaf 1 returns zero in EBX and ECX.
// - Leaf 1 EDX sets bits 0, 4, 5, 8, 15 and 23.
// - Every other leaf 1 EDX bit reads as zero.
// - Leaf 80000000h returns 80000005h in EAX and zero elsewhere.
module clr_responder
  import clr_pkg::*;
#(
  // Identity values below are arbitrary.
  parameter logic [95:0] VENDOR_STR = "NeutralCores",
  parameter logic [3:0] STEPPING = 4'h1,
  parameter logic [3:0] MODEL = 4'h2,
  parameter logic [3:0] FAMILY = 4'h3,
  parameter logic [3:0] PTYPE = 4'h1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // Write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // Read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Flag state
  output logic presence_toggle_bit
);

  ////////////////////////////////////////////////////////////////////////
  localparam clr_state_t RST = '{
    fsm: CLR_IDLE,
    opc: `CLR_OPC_RST,
    pres: `CLR_PRES_RST,
    default: '0
  };

  clr_state_t s_q;
  clr_state_t s_d;
  clr_leaf_if lk ();

  logic wr;
  logic rd;
  logic wr_ctrl;
  logic stat_clr;
  logic pres_in;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic is_mapped(input logic [7:0] a);
    return a == `CLR_OFF_CTRL || a == `CLR_OFF_OPC ||
      a == `CLR_OFF_STAT || a == `CLR_OFF_EAX || a == `CLR_OFF_EBX ||
      a == `CLR_OFF_ECX || a == `CLR_OFF_EDX;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8 * i +: 8] = nw[8 * i +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Address and data are taken together in one beat; the master holds
  // both valid until then, so waiting for the pair costs one cycle only.
  assign wr = s_q.aw_rdy && awvalid && s_q.w_rdy && wvalid;
  assign rd = s_q.ar_rdy && arvalid;
  assign wr_ctrl = wr && awaddr == `CLR_OFF_CTRL;
  assign stat_clr = wr && awaddr == `CLR_OFF_STAT && wstrb[0] &&
    wdata[`CLR_DONE_BIT];
  assign pres_in = wdata[`CLR_PRES_BIT];
  assign lk.leaf = s_q.eax;

  clr_leaf_table #(
    .VENDOR_STR(VENDOR_STR),
    .STEPPING(STEPPING),
    .MODEL(MODEL),
    .FAMILY(FAMILY),
    .PTYPE(PTYPE)
  ) u_table (
    .lk(lk)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [31:0] ctrl_w;
    logic [31:0] stat_w;
    logic done_set;
    logic bad_set;
    logic [31:0] mw;
    s_d = s_q;
    mw = '0;
    ctrl_w = '0;
    ctrl_w[`CLR_PRES_BIT] = s_q.pres;
    stat_w = '0;
    stat_w[`CLR_DONE_BIT] = s_q.done;
    stat_w[`CLR_BADOP_BIT] = s_q.bad_op;
    done_set = 1'b0;
    bad_set = 1'b0;

    // Ready strobes are one-cycle pulses, never raised while an answer
    // is still waiting to be taken.
    s_d.aw_rdy = awvalid && wvalid && !s_q.bvalid && !s_q.aw_rdy;
    s_d.w_rdy = awvalid && wvalid && !s_q.bvalid && !s_q.w_rdy;
    s_d.ar_rdy = arvalid && !s_q.rvalid && !s_q.ar_rdy;

    // A start that arrives while a query runs is kept for the next idle.
    s_d.start = s_q.start && s_q.fsm != CLR_IDLE;

    if (wr) begin
      s_d.bvalid = 1'b1;
      s_d.bresp = is_mapped(awaddr) ? `CLR_RESP_OK : `CLR_RESP_ERR;
      unique case (awaddr)
        `CLR_OFF_CTRL: begin
          mw = merge(ctrl_w, wdata, wstrb);
          s_d.pres = mw[`CLR_PRES_BIT];
          if (wstrb[0] && wdata[`CLR_START_BIT]) begin
            s_d.start = 1'b1;
          end
        end
        `CLR_OFF_OPC: begin
          mw = merge({16'h0000, s_q.opc}, wdata, wstrb);
          s_d.opc = mw[15:0];
        end
        `CLR_OFF_EAX: begin
          s_d.eax = merge(s_q.eax, wdata, wstrb);
        end
        `CLR_OFF_EBX: begin
          s_d.ebx = merge(s_q.ebx, wdata, wstrb);
        end
        `CLR_OFF_ECX: begin
          s_d.ecx = merge(s_q.ecx, wdata, wstrb);
        end
        `CLR_OFF_EDX: begin
          s_d.edx = merge(s_q.edx, wdata, wstrb);
        end
        default: begin
          s_d.bvalid = 1'b1;
        end
      endcase
    end else if (bready) begin
      s_d.bvalid = 1'b0;
    end

    if (rd) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = is_mapped(araddr) ? `CLR_RESP_OK : `CLR_RESP_ERR;
      unique case (araddr)
        `CLR_OFF_CTRL: s_d.rdata = ctrl_w;
        `CLR_OFF_OPC: s_d.rdata = {16'h0000, s_q.opc};
        `CLR_OFF_STAT: s_d.rdata = stat_w;
        `CLR_OFF_EAX: s_d.rdata = s_q.eax;
        `CLR_OFF_EBX: s_d.rdata = s_q.ebx;
        `CLR_OFF_ECX: s_d.rdata = s_q.ecx;
        `CLR_OFF_EDX: s_d.rdata = s_q.edx;
        default: s_d.rdata = '0;
      endcase
    end else if (rready) begin
      s_d.rvalid = 1'b0;
    end

    unique case (s_q.fsm)
      CLR_IDLE: begin
        if (s_q.start) begin
          s_d.start = wr_ctrl && wstrb[0] && wdata[`CLR_START_BIT];
          if (s_q.opc == `CLR_QUERY_OPC) begin
            s_d.fsm = CLR_EXEC;
          end else begin
            bad_set = 1'b1;
            done_set = 1'b1;
          end
        end
      end
      CLR_EXEC: begin
        // The table result overrides a software write in the same cycle.
        s_d.eax = lk.eax;
        s_d.ebx = lk.ebx;
        s_d.ecx = lk.ecx;
        s_d.edx = lk.edx;
        done_set = 1'b1;
        s_d.fsm = CLR_IDLE;
      end
      default: begin
        s_d.fsm = CLR_IDLE;
      end
    endcase

    // Both status bits are cleared by writing one to the done bit; a new event wins.
    s_d.done = done_set || (s_q.done && !stat_clr);
    s_d.bad_op = bad_set || (s_q.bad_op && !stat_clr);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign awready = s_q.aw_rdy;
  assign wready = s_q.w_rdy;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.ar_rdy;
  assign rvalid = s_q.rvalid;
  assign rresp = s_q.rresp;
  assign rdata = s_q.rdata;
  assign presence_toggle_bit = s_q.pres;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_opcode_gate: assert property (
    s_q.start && s_q.fsm == CLR_IDLE && s_q.opc != `CLR_QUERY_OPC
    |=> s_q.bad_op && s_q.done && s_q.fsm == CLR_IDLE
  ) else $error("wrong opcode was executed");

  a_presence_write: assert property (
    wr_ctrl && wstrb[2] |=> presence_toggle_bit == $past(pres_in)
  ) else $error("presence bit did not take the written value");

  a_leaf_results: assert property (
    s_q.fsm == CLR_EXEC |=> s_q.done && s_q.fsm == CLR_IDLE &&
      s_q.ebx == $past(lk.ebx) && s_q.edx == $past(lk.edx)
  ) else $error("results not written from the selected leaf");

  a_query_latency: assert property (
    s_q.start && s_q.fsm == CLR_IDLE && s_q.opc == `CLR_QUERY_OPC
    |=> s_q.fsm == CLR_EXEC ##1 s_q.fsm == CLR_IDLE && s_q.done
  ) else $error("query did not finish in two cycles");

  a_std_max_leaf: assert property (
    s_q.fsm == CLR_EXEC && s_q.eax == `CLR_LEAF_STD0
    |=> s_q.eax == `CLR_STD_MAX
  ) else $error("leaf 0 highest leaf wrong");

  a_vendor_order: assert property (
    s_q.fsm == CLR_EXEC && s_q.eax == `CLR_LEAF_STD0
    |=> s_q.ebx[7:0] == VENDOR_STR[95:88] &&
      s_q.edx[7:0] == VENDOR_STR[63:56] &&
      s_q.ecx[7:0] == VENDOR_STR[31:24]
  ) else $error("vendor string order wrong");

  a_version_word: assert property (
    s_q.fsm == CLR_EXEC && s_q.eax == `CLR_LEAF_VER
    |=> s_q.eax == {16'h0000, PTYPE, FAMILY, MODEL, STEPPING} &&
      s_q.ebx == '0 && s_q.ecx == '0
  ) else $error("leaf 1 version word wrong");

  a_leaf1_flags: assert property (
    s_q.fsm == CLR_EXEC && s_q.eax == `CLR_LEAF_VER
    |=> s_q.edx == `CLR_STD_FEAT
  ) else $error("leaf 1 feature flags wrong");

  a_ext_max_leaf: assert property (
    s_q.fsm == CLR_EXEC && s_q.eax == `CLR_EXT_BASE
    |=> s_q.eax == `CLR_EXT_MAX && s_q.ebx == '0 && s_q.edx == '0
  ) else $error("highest extended leaf wrong");

  a_unknown_zero: assert property (
    s_q.fsm == CLR_EXEC && s_q.eax > `CLR_LEAF_XL1
    |=> s_q.eax == '0 && s_q.ebx == '0 && s_q.ecx == '0 && s_q.edx == '0
  ) else $error("unsupported leaf not zero");

  a_leaf_gap: assert property (
    s_q.fsm == CLR_EXEC && s_q.eax > `CLR_LEAF_CACHE &&
      s_q.eax < `CLR_EXT_BASE
    |=> s_q.eax == '0 && s_q.ebx == '0 && s_q.ecx == '0 && s_q.edx == '0
  ) else $error("leaf between the two ranges not zero");

  a_ext_version: assert property (
    s_q.fsm == CLR_EXEC && s_q.eax == `CLR_LEAF_XVER
    |=> s_q.eax == {16'h0000, PTYPE, FAMILY, MODEL, STEPPING} &&
      s_q.edx == `CLR_EXT_FEAT
  ) else $error("extended version leaf wrong");

  a_cache_words: assert property (
    s_q.fsm == CLR_EXEC && s_q.eax == `CLR_LEAF_CACHE
    |=> s_q.eax == `CLR_CACHE_EAX && s_q.edx == `CLR_CACHE_EDX &&
      s_q.ebx == '0 && s_q.ecx == '0
  ) else $error("cache descriptor leaf wrong");

  a_name_text: assert property (
    s_q.fsm == CLR_EXEC && s_q.eax >= `CLR_LEAF_NAME0 &&
      s_q.eax <= `CLR_LEAF_NAME2
    |=> s_q.eax[7:0] != 8'h00 && s_q.ebx[7:0] != 8'h00 &&
      s_q.ecx[7:0] != 8'h00 && s_q.edx[31:24] != 8'h00
  ) else $error("product name leaf holds no text");

  a_l1_words: assert property (
    s_q.fsm == CLR_EXEC && s_q.eax == `CLR_LEAF_XL1
    |=> s_q.eax == '0 && s_q.edx == '0
  ) else $error("first-level cache leaf wrong");

  a_leaf1_clear: assert property (
    s_q.fsm == CLR_EXEC && s_q.eax == `CLR_LEAF_VER
    |=> s_q.edx[31:24] == '0 && s_q.edx[22:16] == '0 &&
      s_q.edx[14:9] == '0 && s_q.edx[7:6] == '0 && s_q.edx[3:1] == '0
  ) else $error("unsupported leaf 1 feature bit set");

  a_write_answer: assert property (
    wr |=> s_q.bvalid
  ) else $error("write taken without a response");

  a_done_sticky: assert property (
    s_q.done && !stat_clr |=> s_q.done
  ) else $error("done flag dropped without a clear");

endmodule

// File: include/clr_map.svh
`ifndef CLR_MAP_SVH
`define CLR_MAP_SVH
// Register byte offsets.
`define CLR_OFF_CTRL 8'h00
`define CLR_OFF_OPC 8'h04
`define CLR_OFF_STAT 8'h08
`define CLR_OFF_EAX 8'h10
`define CLR_OFF_EBX 8'h14
`define CLR_OFF_ECX 8'h18
`define CLR_OFF_EDX 8'h1c
// Field positions and reset values.
`define CLR_START_BIT 0
`define CLR_PRES_BIT 21
`define CLR_DONE_BIT 0
`define CLR_BADOP_BIT 1
`define CLR_OPC_RST 16'h0000
`define CLR_PRES_RST 1'b0
// Query opcode and leaf numbers.
`define CLR_QUERY_OPC 16'h0fa2
`define CLR_LEAF_STD0 32'h0000_0000
`define CLR_LEAF_VER 32'h0000_0001
`define CLR_LEAF_CACHE 32'h0000_0002
`define CLR_EXT_BASE 32'h8000_0000
`define CLR_LEAF_XVER 32'h8000_0001
`define CLR_LEAF_NAME0 32'h8000_0002
`define CLR_LEAF_NAME1 32'h8000_0003
`define CLR_LEAF_NAME2 32'h8000_0004
`define CLR_LEAF_XL1 32'h8000_0005
`define CLR_NAME_FIRST 3'h2
// Returned constants.
`define CLR_STD_MAX 32'h0000_0002
`define CLR_EXT_MAX 32'h8000_0005
`define CLR_STD_FEAT 32'h0080_8131
`define CLR_EXT_FEAT 32'h0180_8131
`define CLR_CACHE_EAX 32'h0000_7001
`define CLR_CACHE_EDX 32'h0000_0080
// Bus answers.
`define CLR_RESP_OK 2'b00
`define CLR_RESP_ERR 2'b10
`endif

// File: include/clr_pkg.sv
package clr_pkg;
  typedef enum logic [1:0] {
    CLR_IDLE = 2'b01,
    CLR_EXEC = 2'b10
  } clr_fsm_t;

  typedef struct packed {
    clr_fsm_t fsm;
    logic start;
    logic pres;
    logic [15:0] opc;
    logic [31:0] eax;
    logic [31:0] ebx;
    logic [31:0] ecx;
    logic [31:0] edx;
    logic done;
    logic bad_op;
    logic aw_rdy;
    logic w_rdy;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } clr_state_t;
endpackage

// File: include/clr_leaf_if.sv
`timescale 1ns/1ps
interface clr_leaf_if;
  logic [31:0] leaf;
  logic [31:0] eax;
  logic [31:0] ebx;
  logic [31:0] ecx;
  logic [31:0] edx;
  modport req (output leaf, input eax, input ebx, input ecx, input edx);
  modport tbl (input leaf, output eax, output ebx, output ecx, output edx);
endinterface

// File: rtl/clr_leaf_table.sv
`timescale 1ns/1ps
`include "clr_map.svh"
module clr_leaf_table #(
  // Identity values below are arbitrary.
  parameter logic [95:0] VENDOR_STR = "NeutralCores",
  parameter logic [383:0] NAME_STR =
    "Generic Identity Query Responder, Neutral Build.",
  parameter logic [3:0] STEPPING = 4'h1,
  parameter logic [3:0] MODEL = 4'h2,
  parameter logic [3:0] FAMILY = 4'h3,
  parameter logic [3:0] PTYPE = 4'h1,
  parameter logic [31:0] XL1_TLB = 32'h0000_0000,
  parameter logic [31:0] XL1_CACHE = 32'h0000_0000
) (
  // Leaf request and result words
  clr_leaf_if.tbl lk
);

  ////////////////////////////////////////////////////////////////////////
  // Strings are packed first character in the low byte of each word.
  function automatic logic [31:0] swap32(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  function automatic logic [31:0] name_word(input logic [3:0] k);
    return swap32(NAME_STR[383 - 32 * k -: 32]);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [1:0] n;
    n = 2'(lk.leaf[2:0] - `CLR_NAME_FIRST);
    lk.eax = '0;
    lk.ebx = '0;
    lk.ecx = '0;
    lk.edx = '0;
    case (lk.leaf)
      `CLR_LEAF_STD0: begin
        lk.eax = `CLR_STD_MAX;
        lk.ebx = swap32(VENDOR_STR[95:64]);
        lk.edx = swap32(VENDOR_STR[63:32]);
        lk.ecx = swap32(VENDOR_STR[31:0]);
      end
      `CLR_LEAF_VER, `CLR_LEAF_XVER: begin
        lk.eax = {16'h0000, PTYPE, FAMILY, MODEL, STEPPING};
        lk.edx = lk.leaf[31] ? `CLR_EXT_FEAT : `CLR_STD_FEAT;
      end
      `CLR_LEAF_CACHE: begin
        lk.eax = `CLR_CACHE_EAX;
        lk.edx = `CLR_CACHE_EDX;
      end
      `CLR_EXT_BASE: begin
        lk.eax = `CLR_EXT_MAX;
      end
      `CLR_LEAF_NAME0, `CLR_LEAF_NAME1, `CLR_LEAF_NAME2: begin
        lk.eax = name_word({n, 2'd0});
        lk.ebx = name_word({n, 2'd1});
        lk.ecx = name_word({n, 2'd2});
        lk.edx = name_word({n, 2'd3});
      end
      `CLR_LEAF_XL1: begin
        lk.ebx = XL1_TLB;
        lk.ecx = XL1_CACHE;
      end
      default: begin
        lk.eax = '0;
      end
    endcase
  end

endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
`include "clr_map.svh"
module tb
  import clr_pkg::*;
;
  // Identity values below are arbitrary and match the design defaults.
  localparam logic [95:0] VEND = "NeutralCores";
  localparam logic [383:0] NAME =
    "Generic Identity Query Responder, Neutral Build.";
  localparam logic [3:0] STEP = 4'h1;
  localparam logic [3:0] MODL = 4'h2;
  localparam logic [3:0] FAM = 4'h3;
  localparam logic [3:0] PTYP = 4'h1;
  // Clock and reset
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  // Bus signals
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic presence_toggle_bit;
  int fails = 0;
  int cmp_count = 0;
  integer seed = 52950;

  clr_responder #(.VENDOR_STR(VEND), .STEPPING(STEP), .MODEL(MODL),
    .FAMILY(FAM), .PTYPE(PTYP)) uut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .presence_toggle_bit(presence_toggle_bit));

  initial begin
    forever #25 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (fails == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Ready outputs are registered, so they are sampled at the falling edge
  // and the handshake completes at the following rising edge.
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    int n;
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd) && n < 100) begin
      @(negedge aclk);
      if (awready === 1'b1) ad = 1'b1;
      if (wready === 1'b1) wd = 1'b1;
      @(posedge aclk);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
      n++;
    end
    r = 2'bxx;
    while (n < 100) begin
      @(negedge aclk);
      n++;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
    if (n >= 100) begin
      fails++;
      results();
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 100) begin
      @(negedge aclk);
      n++;
      if (arready === 1'b1) break;
    end
    @(posedge aclk);
    arvalid <= 1'b0;
    while (n < 100) begin
      @(negedge aclk);
      n++;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
    if (n >= 100) begin
      fails++;
      results();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] feat(input logic ext);
    logic [31:0] f;
    f = 32'h0;
    f[0] = 1'b1;
    f[4] = 1'b1;
    f[5] = 1'b1;
    f[8] = 1'b1;
    f[15] = 1'b1;
    f[23] = 1'b1;
    f[24] = ext;
    return f;
  endfunction

  // Character k of an n-character string lands low byte first.
  function automatic logic [31:0] word_of(input logic [383:0] s,
                                          input int n, input int w);
    logic [31:0] r;
    for (int b = 0; b < 4; b++) begin
      r[8*b +: 8] = s[8*(n-1-4*w-b) +: 8];
    end
    return r;
  endfunction

  // Index 0 to 3 stands for EAX, EBX, ECX, EDX.
  function automatic logic [3:0][31:0] expect_leaf(input logic [31:0] lf);
    logic [3:0][31:0] e;
    e = '0;
    case (lf)
      32'h0000_0000: begin
        e[0] = 32'h0000_0002;
        e[1] = word_of({288'h0, VEND}, 12, 0);
        e[3] = word_of({288'h0, VEND}, 12, 1);
        e[2] = word_of({288'h0, VEND}, 12, 2);
      end
      32'h0000_0001, 32'h8000_0001: begin
        e[0] = {16'h0000, PTYP, FAM, MODL, STEP};
        e[3] = feat(lf[31]);
      end
      32'h0000_0002: begin
        e[0] = 32'h0000_7001;
        e[3] = 32'h0000_0080;
      end
      32'h8000_0000: e[0] = 32'h8000_0005;
      32'h8000_0002, 32'h8000_0003, 32'h8000_0004: begin
        for (int i = 0; i < 4; i++) begin
          e[i] = word_of(NAME, 48, 4 * (lf[2:0] - 3'h2) + i);
        end
      end
      default: e = '0;
    endcase
    return e;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic run_query(input logic [31:0] lf, input logic badop);
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0][31:0] e;
    int n;
    n = 0;
    d = 32'h0;
    e = expect_leaf(lf);
    axw(`CLR_OFF_EAX, lf, r);
    chk({30'h0, r}, {30'h0, `CLR_RESP_OK});
    axw(`CLR_OFF_EBX, $random(seed), r);
    axw(`CLR_OFF_ECX, $random(seed), r);
    axw(`CLR_OFF_EDX, $random(seed), r);
    axw(`CLR_OFF_CTRL, 32'h0000_0001, r);
    while (d[0] !== 1'b1 && n < 20) begin
      axr(`CLR_OFF_STAT, d, r);
      n++;
    end
    chk({30'h0, d[1:0]}, {30'h0, badop, 1'b1});
    if (!badop) begin
      axr(`CLR_OFF_EAX, d, r);
      chk(d, e[0]);
      chk({30'h0, r}, {30'h0, `CLR_RESP_OK});
      axr(`CLR_OFF_EBX, d, r);
      chk(d, e[1]);
      axr(`CLR_OFF_ECX, d, r);
      chk(d, e[2]);
      axr(`CLR_OFF_EDX, d, r);
      chk(d, e[3]);
      chk({31'h0, d[4]}, {31'h0, e[3][4]});
    end
    axw(`CLR_OFF_STAT, 32'h0000_0001, r);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    results();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [31:0] lv [11];
    lv = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h8000_0000, 32'h8000_0001,
           32'h8000_0002, 32'h8000_0003, 32'h8000_0004, 32'h8000_0005,
           32'h8000_0006};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values.
    axr(`CLR_OFF_OPC, d, r);
    chk(d, 32'h0);
    chk({31'h0, presence_toggle_bit}, 32'h0);
    // Presence bit toggles both ways and reads back at bit 21 of the control word.
    axw(`CLR_OFF_CTRL, 32'h0020_0000, r);
    axr(`CLR_OFF_CTRL, d, r);
    chk(d, 32'h0020_0000);
    chk({31'h0, presence_toggle_bit}, 32'h1);
    axw(`CLR_OFF_CTRL, 32'h0, r);
    axr(`CLR_OFF_CTRL, d, r);
    chk(d, 32'h0);
    // A start with the wrong opcode must not execute.
    run_query(32'h0, 1'b1);
    axw(`CLR_OFF_OPC, 32'h0000_0fa3, r);
    run_query(32'h1, 1'b1);
    axw(`CLR_OFF_OPC, 32'h0000_0fa2, r);
    axr(`CLR_OFF_OPC, d, r);
    chk(d, 32'h0000_0fa2);
    // Every documented leaf plus the boundaries just outside.
    foreach (lv[i]) begin
      run_query(lv[i], 1'b0);
    end
    // Random leaves, mostly unsupported.
    repeat (8) begin
      run_query($random(seed), 1'b0);
    end
    // Unmapped address answers with an error and no data.
    axw(8'h0c, 32'hffff_ffff, r);
    chk({30'h0, r}, 32'h2);
    axr(8'h0c, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, 32'h2);
    results();
  end
endmodule
